// ===== pbm_defines.svh
/*
 * constants of the port-b pin function block: register offsets,
 * field positions and reset values.
 * assumes: included by bare name from the mux, detect and top modules and the testbench.
 */
//
// Behaviour
// - direction 0 drives output latch, even with analog channel selected
// - direction 1 samples pin; pull-up on only while pullup_disable_n is clear
// - analog pins 8, 9 and 11 lose digital input and pull-up
// - bits 4 to 7 are change-detect inputs only while set as inputs
// - bit 2 input feeds edge-triggered external interrupt 2
// - capcmp_unit_2 on bit 3: compare/pwm out at dir 0, capture in at dir 1
// - bit 5 drives comparator1_result when enabled and direction is output
// - debug active: bit 6 debug clock in, bit 7 debug data out
// - one active-low bit 7 enables all pull-ups; disabled after reset
// - mismatches against the value at the last pin register read or write are ORed into port_change_flag
// - pull-up switches off while the pin is an output
// - debug active disables all other functions of bits 6 and 7
`ifndef PBM_DEFINES_SVH
`define PBM_DEFINES_SVH

// ************************************************
// register offsets
// ************************************************
`define PBM_OFS_LATCH 8'h00
`define PBM_OFS_DIR 8'h04
`define PBM_OFS_PIN 8'h08
`define PBM_OFS_CTRL 8'h0C
`define PBM_OFS_ANALOG 8'h10
`define PBM_OFS_IRQ_STAT 8'h14
`define PBM_OFS_IRQ_CLR 8'h18
`define PBM_OFS_IRQ_EN 8'h1C

// ************************************************
// field positions
// ************************************************
`define PBM_CTRL_CAPCMP_UNIT_2_ALT 0
`define PBM_CTRL_CMP1_OE 1
`define PBM_CTRL_EXT2_RISE 2
`define PBM_CTRL_PU_DIS_N 7
`define PBM_IRQ_CHANGE 0
`define PBM_IRQ_EXT2 1

// ************************************************
// reset values
// ************************************************
`define PBM_LATCH_RST 8'h00
`define PBM_DIR_RST 8'hFF
`define PBM_CTRL_RST 8'h84
`define PBM_ANALOG_RST 3'h7
`define PBM_IRQ_RST 2'h0

`endif

// ===== pbm_pkg.sv
/*
 * types shared by the port-b pin function block.
 * assumes: nothing.
 */
`default_nettype none
package pbm_pkg;
    typedef logic [7:0] pbm_byte_type;
    typedef logic [1:0] pbm_irq_type;
    typedef enum logic [0:0] {
        PBM_BUS_SETUP = 1'b0,
        PBM_BUS_ACCESS = 1'b1
    } pbm_bus_phase_type;
endpackage
`default_nettype wire

// ===== pbm_pin_mux.sv
/*
 * per-pin function selection: drive, enable, pull-up and gated input.
 * assumes: purely combinational; the caller registers the results.
 */
`timescale 1ns/1ns
`default_nettype none
`include "pbm_defines.svh"
module pbm_pin_mux (
    input wire pbm_pkg::pbm_byte_type pad_i,
    input wire pbm_pkg::pbm_byte_type direction_bits_i,
    input wire pbm_pkg::pbm_byte_type output_latch_i,
    input wire logic pullup_disable_n_i,
    input wire logic [2:0] analog_sel_i,
    input wire logic capcmp_unit_2_alt_i,
    input wire logic capcmp_unit_2_out_i,
    input wire logic cmp1_oe_i,
    input wire logic comparator1_result_i,
    input wire logic debug_active_i,
    input wire logic debug_data_out_i,
    output pbm_pkg::pbm_byte_type out_o,
    output pbm_pkg::pbm_byte_type oe_o,
    output pbm_pkg::pbm_byte_type pullup_o,
    output pbm_pkg::pbm_byte_type dig_in_o
);
    // ************************************************
    // analog map: bit2 ch8, bit3 ch9, bit4 ch11
    // ************************************************
    pbm_pkg::pbm_byte_type ana;
    pbm_pkg::pbm_byte_type dbg;
    assign ana = {3'h0, analog_sel_i[2], analog_sel_i[1], analog_sel_i[0], 2'h0};
    assign dbg = {debug_active_i, debug_active_i, 6'h00};

    always_comb begin
        out_o = output_latch_i;
        oe_o = ~direction_bits_i;
        if (capcmp_unit_2_alt_i && !direction_bits_i[3]) begin
            out_o[3] = capcmp_unit_2_out_i;
        end
        if (cmp1_oe_i && !direction_bits_i[5]) begin
            out_o[5] = comparator1_result_i;
        end
        if (debug_active_i) begin
            oe_o[6] = 1'b0;
            oe_o[7] = 1'b1;
            out_o[6] = 1'b0;
            out_o[7] = debug_data_out_i;
        end
        // pull-up: input only, common enable, not analog, not debug
        pullup_o = direction_bits_i & {8{~pullup_disable_n_i}} & ~ana & ~dbg;
        dig_in_o = pad_i & ~ana & ~dbg;
    end
endmodule
`default_nettype wire

// ===== pbm_change_det.sv
/*
 * change detect on bits 4..7 and edge detect on bit 2.
 * assumes: pin values already gated by analog and debug selection.
 */
`timescale 1ns/1ns
`default_nettype none
`include "pbm_defines.svh"
module pbm_change_det (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire pbm_pkg::pbm_byte_type dig_in_i,
    input wire pbm_pkg::pbm_byte_type direction_bits_i,
    input wire logic snapshot_i,
    input wire logic rise_sel_i,
    output logic mismatch_o,
    output logic ext2_edge_o
);
    logic [3:0] last_q;
    logic [3:0] last_d;
    logic ext2_q;
    logic ext2_d;

    // ************************************************
    // next state
    // ************************************************
    always_comb begin
        last_d = snapshot_i ? dig_in_i[7:4] : last_q;
        ext2_d = dig_in_i[2] & direction_bits_i[2];
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            last_q <= 4'h0;
            ext2_q <= 1'b0;
        end else begin
            last_q <= last_d;
            ext2_q <= ext2_d;
        end
    end

    // only input pins take part in the comparison
    assign mismatch_o = |((dig_in_i[7:4] ^ last_q) & direction_bits_i[7:4]);
    // edge on an input bit 2 pin
    assign ext2_edge_o = rise_sel_i ? (ext2_d & ~ext2_q) : (~ext2_d & ext2_q);
endmodule
`default_nettype wire

// ===== pbm_port_top.sv
/*
 * port-b upper pin function block: apb registers, pin mux,
 * change and edge interrupts, registered pad drive.
 * assumes: pad inputs and peripheral inputs synchronous to clk_sys_i;
 * pad wire resolved outside from pad_out_o and pad_oe_o.
 */
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "pbm_defines.svh"
module pbm_port_top (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire pbm_pkg::pbm_byte_type pad_i,
    output pbm_pkg::pbm_byte_type pad_out_o,
    output pbm_pkg::pbm_byte_type pad_oe_o,
    output pbm_pkg::pbm_byte_type pullup_en_o,
    input wire logic capcmp_unit_2_out_i,
    input wire logic comparator1_result_i,
    input wire logic debug_active_i,
    input wire logic debug_data_out_i,
    output logic capcmp_unit_2_capture_o,
    output logic timer0_ext_clock_o,
    output logic ext_irq_in2_o,
    output logic debug_clock_pin_o,
    output logic port_change_flag_o,
    output logic irq_o
);
    // ************************************************
    // registers
    // ************************************************
    pbm_pkg::pbm_byte_type output_latch_q;
    pbm_pkg::pbm_byte_type output_latch_d;
    pbm_pkg::pbm_byte_type direction_bits_q;
    pbm_pkg::pbm_byte_type direction_bits_d;
    pbm_pkg::pbm_byte_type ctrl_q;
    pbm_pkg::pbm_byte_type ctrl_d;
    logic [2:0] analog_q;
    logic [2:0] analog_d;
    pbm_pkg::pbm_irq_type stat_q;
    pbm_pkg::pbm_irq_type stat_d;
    pbm_pkg::pbm_irq_type en_q;
    pbm_pkg::pbm_irq_type en_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic err_q;
    logic err_d;

    pbm_pkg::pbm_bus_phase_type phase;
    logic wr_en;
    logic rd_en;
    logic snapshot;
    logic mismatch;
    logic ext2_edge;
    pbm_pkg::pbm_byte_type mux_out;
    pbm_pkg::pbm_byte_type mux_oe;
    pbm_pkg::pbm_byte_type mux_pu;
    pbm_pkg::pbm_byte_type dig_in;

    // ************************************************
    // address decode
    // ************************************************
    function automatic logic addr_known(input logic [7:0] a);
        if (a == `PBM_OFS_LATCH) begin
            return 1'b1;
        end else if (a == `PBM_OFS_DIR) begin
            return 1'b1;
        end else if (a == `PBM_OFS_PIN) begin
            return 1'b1;
        end else if (a == `PBM_OFS_CTRL) begin
            return 1'b1;
        end else if (a == `PBM_OFS_ANALOG) begin
            return 1'b1;
        end else if (a == `PBM_OFS_IRQ_STAT) begin
            return 1'b1;
        end else if (a == `PBM_OFS_IRQ_CLR) begin
            return 1'b1;
        end else if (a == `PBM_OFS_IRQ_EN) begin
            return 1'b1;
        end else begin
            return 1'b0;
        end
    endfunction

    // ************************************************
    // apb handshake
    // ************************************************
    assign phase = penable_i ? pbm_pkg::PBM_BUS_ACCESS : pbm_pkg::PBM_BUS_SETUP;
    assign pready_o = psel_i && (phase == pbm_pkg::PBM_BUS_ACCESS);
    assign pslverr_o = pready_o && err_q;
    assign prdata_o = rdata_q;
    assign wr_en = pready_o && pwrite_i && !err_q;
    assign rd_en = pready_o && !pwrite_i && !err_q;
    // any read or write of the pin register refreshes the compare value
    assign snapshot = (wr_en || rd_en) && (paddr_i == `PBM_OFS_PIN);

    // ************************************************
    // pin mux feeding the event detect
    // ************************************************
    pbm_pin_mux u_mux (
        .pad_i(pad_i),
        .direction_bits_i(direction_bits_q),
        .output_latch_i(output_latch_q),
        .pullup_disable_n_i(ctrl_q[`PBM_CTRL_PU_DIS_N]),
        .analog_sel_i(analog_q),
        .capcmp_unit_2_alt_i(ctrl_q[`PBM_CTRL_CAPCMP_UNIT_2_ALT]),
        .capcmp_unit_2_out_i(capcmp_unit_2_out_i),
        .cmp1_oe_i(ctrl_q[`PBM_CTRL_CMP1_OE]),
        .comparator1_result_i(comparator1_result_i),
        .debug_active_i(debug_active_i),
        .debug_data_out_i(debug_data_out_i),
        .out_o(mux_out),
        .oe_o(mux_oe),
        .pullup_o(mux_pu),
        .dig_in_o(dig_in)
    );

    // ************************************************
    // event detect
    // ************************************************
    pbm_change_det u_det (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .dig_in_i(dig_in),
        .direction_bits_i(direction_bits_q),
        .snapshot_i(snapshot),
        .rise_sel_i(ctrl_q[`PBM_CTRL_EXT2_RISE]),
        .mismatch_o(mismatch),
        .ext2_edge_o(ext2_edge)
    );

    // ************************************************
    // configuration next values
    // ************************************************
    always_comb begin
        output_latch_d = output_latch_q;
        direction_bits_d = direction_bits_q;
        ctrl_d = ctrl_q;
        analog_d = analog_q;
        if (wr_en) begin
            if (paddr_i == `PBM_OFS_LATCH || paddr_i == `PBM_OFS_PIN) begin
                output_latch_d = pwdata_i[7:0];
            end else if (paddr_i == `PBM_OFS_DIR) begin
                direction_bits_d = pwdata_i[7:0];
            end else if (paddr_i == `PBM_OFS_CTRL) begin
                ctrl_d = pwdata_i[7:0] & 8'h87;
            end else if (paddr_i == `PBM_OFS_ANALOG) begin
                analog_d = pwdata_i[2:0];
            end
        end
    end

    // ************************************************
    // interrupt status and enable next values
    // ************************************************
    always_comb begin
        en_d = en_q;
        stat_d = stat_q;
        if (wr_en) begin
            if (paddr_i == `PBM_OFS_IRQ_CLR) begin
                stat_d = stat_q & ~pwdata_i[1:0];
            end else if (paddr_i == `PBM_OFS_IRQ_EN) begin
                en_d = pwdata_i[1:0];
            end
        end
        // set wins over clear; change flag held while mismatch lasts
        if (mismatch) begin
            stat_d[`PBM_IRQ_CHANGE] = 1'b1;
        end
        if (ext2_edge) begin
            stat_d[`PBM_IRQ_EXT2] = 1'b1;
        end
    end

    // ************************************************
    // read data, latched in the setup cycle
    // ************************************************
    always_comb begin
        rdata_d = 32'h0000_0000;
        err_d = 1'b0;
        if (psel_i && phase == pbm_pkg::PBM_BUS_SETUP) begin
            err_d = !addr_known(paddr_i);
            if (paddr_i == `PBM_OFS_LATCH) begin
                rdata_d[7:0] = output_latch_q;
            end else if (paddr_i == `PBM_OFS_DIR) begin
                rdata_d[7:0] = direction_bits_q;
            end else if (paddr_i == `PBM_OFS_PIN) begin
                rdata_d[7:0] = dig_in;
            end else if (paddr_i == `PBM_OFS_CTRL) begin
                rdata_d[7:0] = ctrl_q;
            end else if (paddr_i == `PBM_OFS_ANALOG) begin
                rdata_d[2:0] = analog_q;
            end else if (paddr_i == `PBM_OFS_IRQ_STAT) begin
                rdata_d[1:0] = stat_q;
            end else if (paddr_i == `PBM_OFS_IRQ_EN) begin
                rdata_d[1:0] = en_q;
            end
        end else if (psel_i) begin
            rdata_d = rdata_q;
            err_d = err_q;
        end
    end

    // ************************************************
    // configuration storage
    // ************************************************
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            output_latch_q <= `PBM_LATCH_RST;
            direction_bits_q <= `PBM_DIR_RST;
            ctrl_q <= `PBM_CTRL_RST;
            analog_q <= `PBM_ANALOG_RST;
        end else begin
            output_latch_q <= output_latch_d;
            direction_bits_q <= direction_bits_d;
            ctrl_q <= ctrl_d;
            analog_q <= analog_d;
        end
    end

    // ************************************************
    // interrupt storage
    // ************************************************
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            stat_q <= `PBM_IRQ_RST;
            en_q <= `PBM_IRQ_RST;
        end else begin
            stat_q <= stat_d;
            en_q <= en_d;
        end
    end

    // ************************************************
    // read data storage
    // ************************************************
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_q <= 32'h0000_0000;
            err_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            err_q <= err_d;
        end
    end

    // ************************************************
    // pad and peripheral outputs
    // ************************************************
    pbm_pkg::pbm_byte_type pad_out_d;
    pbm_pkg::pbm_byte_type pad_oe_d;
    pbm_pkg::pbm_byte_type pu_d;
    logic [3:0] periph_d;
    logic [3:0] periph_q;
    pbm_pkg::pbm_byte_type pad_out_q;
    pbm_pkg::pbm_byte_type pad_oe_q;
    pbm_pkg::pbm_byte_type pu_q;

    always_comb begin
        pad_out_d = mux_out;
        pad_oe_d = mux_oe;
        pu_d = mux_pu;
        // capture input only on alternate mapping with bit 3 an input
        periph_d[0] = ctrl_q[`PBM_CTRL_CAPCMP_UNIT_2_ALT] & direction_bits_q[3] & dig_in[3];
        periph_d[1] = direction_bits_q[5] & dig_in[5];
        periph_d[2] = direction_bits_q[2] & dig_in[2];
        periph_d[3] = debug_active_i & pad_i[6];
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            pad_out_q <= 8'h00;
            pad_oe_q <= 8'h00;
            pu_q <= 8'h00;
            periph_q <= 4'h0;
        end else begin
            pad_out_q <= pad_out_d;
            pad_oe_q <= pad_oe_d;
            pu_q <= pu_d;
            periph_q <= periph_d;
        end
    end

    assign pad_out_o = pad_out_q;
    assign pad_oe_o = pad_oe_q;
    assign pullup_en_o = pu_q;
    assign capcmp_unit_2_capture_o = periph_q[0];
    assign timer0_ext_clock_o = periph_q[1];
    assign ext_irq_in2_o = periph_q[2];
    assign debug_clock_pin_o = periph_q[3];

    // ************************************************
    // interrupt outputs
    // ************************************************
    assign port_change_flag_o = stat_q[`PBM_IRQ_CHANGE];
    assign irq_o = |(stat_q & en_q);
endmodule
`default_nettype wire

// ===== pbm_port_properties.sv
/* checker: pin function properties seen at the top ports.
   assumes: bound into pbm_port_top, one clock domain. */
`timescale 1ns/1ns
`default_nettype none
module pbm_port_properties (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire pbm_pkg::pbm_byte_type pad_i,
    input wire pbm_pkg::pbm_byte_type pad_out_o,
    input wire pbm_pkg::pbm_byte_type pad_oe_o,
    input wire pbm_pkg::pbm_byte_type pullup_en_o,
    input wire logic debug_active_i,
    input wire logic debug_data_out_i,
    input wire logic debug_clock_pin_o,
    input wire logic timer0_ext_clock_o,
    input wire logic ext_irq_in2_o
);
    // ****
    // clocking
    // ****
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (reset_i);
    // ****
    // properties
    // ****
    AST_READY_COMB: assert property (pready_o == (psel_i && penable_i))
        else $error("pready not psel and penable");
    AST_ERR_IN_ACCESS: assert property (pslverr_o |-> pready_o)
        else $error("pslverr outside access");
    AST_RESET_PULLS: assert property ($past(reset_i) |=> pullup_en_o == 8'h00)
        else $error("pull-up on after reset");
    AST_NO_PULL_ON_OUT: assert property ((pullup_en_o & pad_oe_o) == 8'h00)
        else $error("pull-up on a driven pin");
    AST_DEBUG_DATA: assert property (!$past(reset_i) && $past(debug_active_i) |->
        pad_oe_o[7] && pad_out_o[7] == $past(debug_data_out_i))
        else $error("debug data not on bit 7");
    AST_DEBUG_PIN6: assert property (!$past(reset_i) && $past(debug_active_i) |->
        !pad_oe_o[6] && pullup_en_o[7:6] == 2'h0)
        else $error("debug pins keep other functions");
    AST_DEBUG_CLK: assert property (!$past(reset_i) && $past(debug_active_i) |->
        debug_clock_pin_o == $past(pad_i[6]))
        else $error("debug clock not from bit 6");
    AST_TMR0_FOLLOW: assert property (!$past(reset_i) && !pad_oe_o[5] |->
        timer0_ext_clock_o == $past(pad_i[5]))
        else $error("timer clock not from bit 5");
    AST_EXT2_FOLLOW: assert property (pullup_en_o[2] |-> ext_irq_in2_o == $past(pad_i[2]))
        else $error("ext irq 2 not from bit 2");
endmodule
bind pbm_port_top pbm_port_properties pbm_port_properties_inst (.clk_sys_i, .reset_i,
    .psel_i, .penable_i, .pready_o, .pslverr_o, .pad_i, .pad_out_o, .pad_oe_o,
    .pullup_en_o, .debug_active_i, .debug_data_out_i, .debug_clock_pin_o,
    .timer0_ext_clock_o, .ext_irq_in2_o);
`default_nettype wire

// ===== pbm_pad_model.sv
/* partner: board-level model of the eight port pins.
   assumes: clocked by clk_sys_i; board drive given per pin. */
`timescale 1ns/1ns
`default_nettype none
module pbm_pad_model (
    input wire logic clk_sys_i,
    input wire pbm_pkg::pbm_byte_type pad_out_i,
    input wire pbm_pkg::pbm_byte_type pad_oe_i,
    input wire pbm_pkg::pbm_byte_type pullup_en_i,
    input wire pbm_pkg::pbm_byte_type ext_val_i,
    input wire pbm_pkg::pbm_byte_type ext_en_i,
    output pbm_pkg::pbm_byte_type pad_o
);
    pbm_pkg::pbm_byte_type float_q = 8'h00;
    // ****
    // pin resolution
    // ****
    always_ff @(posedge clk_sys_i) begin
        float_q <= ~pad_o;
    end
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pad_oe_i[i]) begin
                pad_o[i] = pad_out_i[i];
            end else if (ext_en_i[i]) begin
                pad_o[i] = ext_val_i[i];
            end else begin
                pad_o[i] = pullup_en_i[i] | float_q[i];
            end
        end
    end
endmodule
`default_nettype wire

// ===== tb_top.sv
/* testbench: apb and pin scenarios for pbm_port_top.
   assumes: design, checker and pad model compiled first. */
`timescale 1ns/1ns
`default_nettype none
`include "pbm_defines.svh"
module tb_top;
    logic clk_sys_i = 1'h0;
    logic reset_i = 1'h1;
    logic psel_i = 1'h0;
    logic penable_i = 1'h0;
    logic pwrite_i = 1'h0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic capcmp_unit_2_out_i = 1'h0;
    logic comparator1_result_i = 1'h0;
    logic debug_active_i = 1'h0;
    logic debug_data_out_i = 1'h0;
    logic [31:0] prdata_o;
    logic pready_o, pslverr_o, capcmp_unit_2_capture_o, timer0_ext_clock_o, ext_irq_in2_o;
    logic debug_clock_pin_o, port_change_flag_o, irq_o;
    pbm_pkg::pbm_byte_type pad_i, pad_out_o, pad_oe_o, pullup_en_o;
    pbm_pkg::pbm_byte_type ext_val = 8'h00;
    logic look = 1'h0;
    logic [7:0] latch_s, dir_s, ctrl_s;
    logic [2:0] an_s;
    logic [31:0] obs, r;
    logic [63:0] e, px;
    logic [63:0] q[$];
    int error_cnt = 0;
    int compares = 0;
    int cyc = 0;
    integer seed = 32'hE8EA7FDC;
    // ****
    // structure
    // ****
    always #25 clk_sys_i = ~clk_sys_i;
    pbm_port_top pbm_port_top_inst (.clk_sys_i, .reset_i, .psel_i, .penable_i, .pwrite_i,
        .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .pad_i, .pad_out_o, .pad_oe_o,
        .pullup_en_o, .capcmp_unit_2_out_i, .comparator1_result_i, .debug_active_i, .debug_data_out_i,
        .capcmp_unit_2_capture_o, .timer0_ext_clock_o, .ext_irq_in2_o, .debug_clock_pin_o,
        .port_change_flag_o, .irq_o);
    pbm_pad_model pbm_pad_model_inst (.clk_sys_i, .pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o),
        .pullup_en_i(pullup_en_o), .ext_val_i(ext_val), .ext_en_i(8'hFF), .pad_o(pad_i));
    // ****
    // monitor and closing
    // ****
    always @(posedge clk_sys_i) begin
        cyc++;
        if ((psel_i && penable_i && pready_o) || look) begin
            obs = look ? {2'h0, capcmp_unit_2_capture_o, timer0_ext_clock_o, ext_irq_in2_o,
                debug_clock_pin_o, port_change_flag_o, irq_o, pullup_en_o, pad_oe_o, pad_out_o}
                : {pslverr_o, pwrite_i ? 31'h0 : prdata_o[30:0]};
            e = q.pop_front();
            compares++;
            if (((obs ^ e[31:0]) & e[63:32]) !== 32'h0) begin
                $display("mismatch %0t got %h exp %h", $time, obs, e[31:0]);
                error_cnt++;
            end
        end
        if (cyc == 5000) begin
            error_cnt++;
            results();
        end
    end
    task automatic results();
        if (error_cnt == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ****
    // bus and pin tasks
    // ****
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [63:0] x);
        q.push_back(x);
        psel_i <= 1'h1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_sys_i);
        penable_i <= 1'h1;
        @(posedge clk_sys_i);
        while (pready_o !== 1'h1) begin
            @(posedge clk_sys_i);
        end
        psel_i <= 1'h0;
        penable_i <= 1'h0;
        @(posedge clk_sys_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'h1, a, {24'h0, d}, {32'hFFFFFFFF, 32'h0});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'h0, a, 32'h0, {32'hFFFFFFFF, x});
    endtask
    task automatic lk(input logic [31:0] m, input logic [31:0] x);
        q.push_back({m, x});
        look <= 1'h1;
        @(posedge clk_sys_i);
        look <= 1'h0;
        @(posedge clk_sys_i);
    endtask
    task automatic cfg(input logic [7:0] l, dr, c, input logic [2:0] n);
        latch_s = l;
        dir_s = dr;
        ctrl_s = c;
        an_s = n;
        wr(`PBM_OFS_LATCH, l);
        wr(`PBM_OFS_DIR, dr);
        wr(`PBM_OFS_CTRL, c);
        wr(`PBM_OFS_ANALOG, {5'h0, n});
    endtask
    function automatic logic [7:0] amk();
        return {3'h0, an_s, 2'h0};
    endfunction
    function automatic logic [63:0] pexp();
        return {16'h00FF, 8'hFF, ~dir_s, 8'h00, dir_s & ~amk() & {8{~ctrl_s[7]}}, ~dir_s, latch_s};
    endfunction
    // ****
    // scenarios
    // ****
    initial begin
        repeat (3) @(posedge clk_sys_i);
        reset_i <= 1'h0;
        @(posedge clk_sys_i);
        lk(32'h3BFFFFFF, 32'h0);
        rd(`PBM_OFS_LATCH, 32'h0);
        rd(`PBM_OFS_DIR, 32'hFF);
        rd(`PBM_OFS_CTRL, 32'h84);
        rd(`PBM_OFS_ANALOG, 32'h7);
        rd(`PBM_OFS_IRQ_STAT, 32'h0);
        rd(`PBM_OFS_IRQ_CLR, 32'h0);
        rd(`PBM_OFS_IRQ_EN, 32'h0);
        rd(8'h20, 32'h80000000);
        apb(1'h1, 8'h24, 32'hFF, {32'hFFFFFFFF, 32'h80000000});
        repeat (8) begin
            r = $random(seed);
            ext_val <= r[31:24];
            cfg(r[7:0], r[15:8], {r[16], 7'h04}, r[19:17]);
            px = pexp();
            lk(px[63:32], px[31:0]);
            rd(`PBM_OFS_PIN, {24'h0, ((dir_s & ext_val) | (~dir_s & latch_s)) & ~amk()});
        end
        ext_val <= 8'h00;
        cfg(8'h00, 8'hFF, 8'h84, 3'h0);
        rd(`PBM_OFS_PIN, 32'h0);
        wr(`PBM_OFS_IRQ_CLR, 8'h03);
        wr(`PBM_OFS_IRQ_EN, 8'h01);
        lk(32'h03000000, 32'h0);
        ext_val <= 8'h10;
        repeat (4) @(posedge clk_sys_i);
        lk(32'h03000000, 32'h03000000);
        rd(`PBM_OFS_IRQ_STAT, 32'h1);
        wr(`PBM_OFS_IRQ_EN, 8'h00);
        wr(`PBM_OFS_IRQ_CLR, 8'h01);
        lk(32'h03000000, 32'h02000000);
        rd(`PBM_OFS_PIN, 32'h10);
        wr(`PBM_OFS_IRQ_CLR, 8'h01);
        lk(32'h02000000, 32'h0);
        wr(`PBM_OFS_DIR, 8'hEF);
        wr(`PBM_OFS_IRQ_CLR, 8'h01);
        repeat (4) @(posedge clk_sys_i);
        lk(32'h02000000, 32'h0);
        ext_val <= 8'h00;
        cfg(8'h00, 8'hFF, 8'h84, 3'h0);
        rd(`PBM_OFS_PIN, 32'h0);
        wr(`PBM_OFS_IRQ_CLR, 8'h03);
        wr(`PBM_OFS_IRQ_EN, 8'h02);
        ext_val <= 8'h04;
        repeat (4) @(posedge clk_sys_i);
        lk(32'h0B000000, 32'h09000000);
        rd(`PBM_OFS_IRQ_STAT, 32'h2);
        wr(`PBM_OFS_CTRL, 8'h80);
        wr(`PBM_OFS_IRQ_CLR, 8'h03);
        ext_val <= 8'h00;
        repeat (4) @(posedge clk_sys_i);
        rd(`PBM_OFS_IRQ_STAT, 32'h2);
        ext_val <= 8'h04;
        wr(`PBM_OFS_ANALOG, 8'h01);
        repeat (2) @(posedge clk_sys_i);
        lk(32'h08000000, 32'h0);
        cfg(8'h00, 8'hD7, 8'h83, 3'h0);
        for (int k = 0; k < 4; k++) begin
            capcmp_unit_2_out_i <= k[0];
            comparator1_result_i <= k[1];
            repeat (2) @(posedge clk_sys_i);
            lk(32'h00002828, {16'h0000, 8'h28, 2'h0, k[1], 1'h0, k[0], 3'h0});
        end
        ext_val <= 8'h28;
        wr(`PBM_OFS_DIR, 8'hFF);
        repeat (2) @(posedge clk_sys_i);
        lk(32'h30000000, 32'h30000000);
        cfg(8'h00, 8'hFF, 8'h04, 3'h0);
        debug_active_i <= 1'h1;
        repeat (2) begin
            r = $random(seed);
            debug_data_out_i <= r[0];
            ext_val <= {1'h0, r[1], 6'h0};
            repeat (2) @(posedge clk_sys_i);
            lk(32'h04C0C080, {5'h0, r[1], 2'h0, 8'h00, 8'h80, r[0], 7'h0});
            rd(`PBM_OFS_PIN, 32'h0);
        end
        debug_active_i <= 1'h0;
        results();
    end
endmodule
`default_nettype wire
